// file: verilog/sacc_conv_ctrl.sv
// Successive-approximation converter control: triggers, sequencer, results, flags
//
// Behaviour
// - One of eight analog inputs is routed to the converter via a mux.
// - Resolution is 10 bits after reset, 8 bits when low resolution set.
// - In 8-bit mode results sit in low eight bits, upper two read zero.
// - Conversion takes programmed sample-hold cycles then ten converter clocks.
// - Converter clock is system clock over two up to over 128.
// - Start from software, external pin rising edge or timer output.
// - Each result goes to its channel register and the last-result register.
// - Completion sets channel done flag and ready flag; both raise interrupt.
// - With DMA attached, rising ready flag issues one transfer request.
// - DMA transfers are 16-bit at full resolution, 8-bit at low resolution.
// - Reading a channel result clears that channel's done flag.
// - Reading last result clears ready flag and last channel's done flag.
// - New result on unread channel sets that channel's overrun flag.
// - Completion while ready flag high sets the general overrun flag.
// - Reading status clears all channel overrun flags and general overrun.
// - Enabling a channel connects its shared pin to the converter.
// - Trigger codes 0-2 pick timer outputs, 6 the external pin.
// - One start converts every enabled channel in turn, then idles.
// - Sleep mode powers up, waits startup, converts, powers down.
// - Software start stays operative while hardware trigger is enabled.
`timescale 1ns/100ps
`default_nettype none
`include "sacc_defs.svh"
module sacc_conv_ctrl
   import sacc_pkg::*;
#(
   parameter int NUM_CH = `SACC_NUM_CH,
   parameter int CH_W = `SACC_CH_W,
   parameter int RES_W = `SACC_RES_W
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_sw_reset,
   input wire logic i_sw_start,
   input wire logic i_hw_trigger_enable,
   input wire logic [2:0] i_hw_trigger_select,
   input wire logic [2:0] i_timer_output_a,
   input wire logic i_ext_trigger_pin,
   input wire logic i_low_resolution_select,
   input wire logic i_sleep_mode,
   input wire logic [`SACC_DIV_W-1:0] i_clock_divider_select,
   input wire logic [`SACC_STARTUP_W-1:0] i_startup_time,
   input wire logic [`SACC_SH_W-1:0] i_sample_hold_time,
   input wire logic [NUM_CH-1:0] i_chan_enable_set,
   input wire logic [NUM_CH-1:0] i_chan_enable_clear,
   input wire logic i_rd_chan_result,
   input wire logic [CH_W-1:0] i_rd_chan_addr,
   input wire logic i_rd_last_result,
   input wire logic i_rd_status,
   input wire logic i_dma_attached,
   input wire logic i_adc_comp,
   output logic [NUM_CH-1:0] o_chan_enabled,
   output logic [NUM_CH-1:0] o_pin_to_adc,
   output logic [CH_W-1:0] o_mux_sel,
   output logic o_adc_power_on,
   output logic o_adc_clk,
   output logic o_adc_sample,
   output logic [RES_W-1:0] o_sar_trial,
   output logic o_busy,
   output logic [RES_W-1:0] o_chan_result,
   output logic [RES_W-1:0] o_last_result_field,
   output logic [CH_W-1:0] o_last_chan,
   output logic [NUM_CH-1:0] o_conv_done_flag,
   output logic o_result_ready_flag,
   output logic [NUM_CH-1:0] o_channel_overrun_flag,
   output logic o_general_overrun_flag,
   output logic o_converter_irq,
   output logic o_dma_req,
   output logic o_dma_size_16
);
   initial begin
      if (NUM_CH > (1 << CH_W)) $error("sacc_conv_ctrl: NUM_CH exceeds CH_W range");
      if (RES_W != `SACC_RES_W) $error("sacc_conv_ctrl: only 10-bit results served");
   end

   // ************************************************************
   // Trigger selection and start detection
   // ************************************************************
   logic hw_src;
   logic hw_src_q;
   logic start_req;

   always_comb begin
      unique case (i_hw_trigger_select)
         `SACC_TRIG_TIMER0: hw_src = i_timer_output_a[0];
         `SACC_TRIG_TIMER1: hw_src = i_timer_output_a[1];
         `SACC_TRIG_TIMER2: hw_src = i_timer_output_a[2];
         `SACC_TRIG_EXT: hw_src = i_ext_trigger_pin;
         default: hw_src = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         hw_src_q <= 1'b0;
      end else begin
         hw_src_q <= hw_src;
      end
   end

   // Software start always counts, hardware edge only when enabled
   assign start_req = i_sw_start
      || (i_hw_trigger_enable && hw_src && !hw_src_q);

   // ************************************************************
   // Channel enables
   // ************************************************************
   logic [NUM_CH-1:0] chan_en_q;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         chan_en_q <= `SACC_RST_CHAN;
      end else if (i_sw_reset) begin
         chan_en_q <= `SACC_RST_CHAN;
      end else begin
         chan_en_q <= (chan_en_q | i_chan_enable_set) & ~i_chan_enable_clear;
      end
   end

   assign o_chan_enabled = chan_en_q;
   assign o_pin_to_adc = chan_en_q;

   // ************************************************************
   // Converter clock
   // ************************************************************
   logic tick;
   logic seq_run;

   sacc_clk_div u_clk_div (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_run(seq_run),
      .i_clock_divider_select(i_clock_divider_select),
      .o_adc_clk(o_adc_clk),
      .o_tick(tick)
   );

   // ************************************************************
   // Conversion sequencer
   // ************************************************************
   sacc_state_t state_q;
   logic [CH_W-1:0] chan_q;
   logic [`SACC_STARTUP_W-1:0] wait_q;
   logic [3:0] bit_cnt_q;
   logic [RES_W-1:0] trial_q;
   logic [RES_W-1:0] trial_d;
   logic [RES_W-1:0] result;
   logic next_found;
   logic [CH_W-1:0] next_chan;
   logic store;

   // Lowest enabled channel at or above the given one; skips disabled ones
   function automatic logic [CH_W:0] find_next(input logic [NUM_CH-1:0] en,
                                               input logic [CH_W:0] from);
      logic [CH_W:0] r;
      r = '0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (en[i] && (i >= int'(from))) begin
            r = {1'b1, CH_W'(i)};
         end
      end
      return r;
   endfunction

   logic [CH_W:0] first_hit;
   logic [CH_W:0] after_hit;
   assign first_hit = find_next(chan_en_q, '0);
   assign after_hit = find_next(chan_en_q, {1'b0, chan_q} + 1'b1);
   assign next_found = after_hit[CH_W];
   assign next_chan = after_hit[CH_W-1:0];

   // Keep the trial bit if the input sits at or above the DAC level
   always_comb begin
      trial_d = trial_q;
      if (!i_adc_comp) begin
         trial_d[bit_cnt_q] = 1'b0;
      end
      if (bit_cnt_q != 4'h0) begin
         trial_d[bit_cnt_q - 4'h1] = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_q <= SACC_IDLE;
         chan_q <= '0;
         wait_q <= '0;
         bit_cnt_q <= '0;
         trial_q <= '0;
      end else if (i_sw_reset) begin
         state_q <= SACC_IDLE;
         chan_q <= '0;
         wait_q <= '0;
         bit_cnt_q <= '0;
         trial_q <= '0;
      end else begin
         unique case (state_q)
            SACC_IDLE: begin
               // Mid-sequence triggers are ignored since only idle looks
               if (start_req && first_hit[CH_W]) begin
                  chan_q <= first_hit[CH_W-1:0];
                  wait_q <= '0;
                  state_q <= i_sleep_mode ? SACC_STARTUP : SACC_SAMPLE;
               end
            end
            SACC_STARTUP: begin
               if (tick) begin
                  wait_q <= wait_q + 1'b1;
                  if (wait_q >= i_startup_time) begin
                     wait_q <= '0;
                     state_q <= SACC_SAMPLE;
                  end
               end
            end
            SACC_SAMPLE: begin
               if (tick) begin
                  wait_q <= wait_q + 1'b1;
               end
               if (wait_q >= `SACC_STARTUP_W'(i_sample_hold_time)) begin
                  wait_q <= '0;
                  bit_cnt_q <= `SACC_CONV_CYCLES - 4'h1;
                  trial_q <= `SACC_SAR_FIRST;
                  state_q <= SACC_CONVERT;
               end
            end
            SACC_CONVERT: begin
               if (tick) begin
                  trial_q <= trial_d;
                  bit_cnt_q <= bit_cnt_q - 4'h1;
                  if (bit_cnt_q == 4'h0) begin
                     state_q <= SACC_STORE;
                  end
               end
            end
            SACC_STORE: begin
               if (next_found) begin
                  chan_q <= next_chan;
                  state_q <= SACC_SAMPLE;
               end else begin
                  state_q <= SACC_IDLE;
               end
            end
            default: state_q <= SACC_IDLE;
         endcase
      end
   end

   assign store = (state_q == SACC_STORE);
   assign seq_run = (state_q != SACC_IDLE);
   assign o_busy = seq_run;
   assign o_mux_sel = chan_q;
   assign o_adc_sample = (state_q == SACC_SAMPLE);
   assign o_sar_trial = trial_q;
   // Normal mode keeps the analog cell powered; sleep mode only while busy
   assign o_adc_power_on = !i_sleep_mode || seq_run;

   // Low resolution keeps the eight upper decisions, shifted down
   assign result = i_low_resolution_select
      ? {2'b00, trial_q[RES_W-1:2]} : trial_q;

   // ************************************************************
   // Results
   // ************************************************************
   sacc_result_mem u_result_mem (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_clear(i_sw_reset),
      .i_we(store),
      .i_waddr(chan_q),
      .i_wdata(result),
      .i_re(i_rd_chan_result),
      .i_raddr(i_rd_chan_addr),
      .o_rdata(o_chan_result)
   );

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_last_result_field <= `SACC_RST_RESULT;
         o_last_chan <= '0;
      end else if (i_sw_reset) begin
         o_last_result_field <= `SACC_RST_RESULT;
         o_last_chan <= '0;
      end else if (store) begin
         o_last_result_field <= result;
         o_last_chan <= chan_q;
      end
   end

   // ************************************************************
   // Flags; a completion in the same cycle as a clearing read wins
   // ************************************************************
   logic [NUM_CH-1:0] done_q;
   logic [NUM_CH-1:0] ovr_q;
   logic ready_q;
   logic govr_q;
   logic [NUM_CH-1:0] done_clr;
   logic [NUM_CH-1:0] done_set;

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_flag
         assign done_set[g] = store && (chan_q == CH_W'(g));
         assign done_clr[g] = (i_rd_chan_result && (i_rd_chan_addr == CH_W'(g)))
            || (i_rd_last_result && (o_last_chan == CH_W'(g)));
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         done_q <= '0;
         ready_q <= 1'b0;
      end else if (i_sw_reset) begin
         done_q <= '0;
         ready_q <= 1'b0;
      end else begin
         done_q <= (done_q & ~done_clr) | done_set;
         ready_q <= store || (ready_q && !i_rd_last_result);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ovr_q <= '0;
         govr_q <= 1'b0;
      end else if (i_sw_reset) begin
         ovr_q <= '0;
         govr_q <= 1'b0;
      end else begin
         ovr_q <= (i_rd_status ? '0 : ovr_q) | (done_set & done_q);
         govr_q <= (govr_q && !i_rd_status) || (store && ready_q);
      end
   end

   assign o_conv_done_flag = done_q;
   assign o_result_ready_flag = ready_q;
   assign o_channel_overrun_flag = ovr_q;
   assign o_general_overrun_flag = govr_q;
   assign o_converter_irq = ready_q || (|done_q);

   // ************************************************************
   // DMA request
   // ************************************************************
   logic ready_prev_q;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ready_prev_q <= 1'b0;
         o_dma_req <= 1'b0;
      end else begin
         ready_prev_q <= ready_q;
         o_dma_req <= i_dma_attached && ready_q && !ready_prev_q;
      end
   end

   assign o_dma_size_16 = !i_low_resolution_select;
endmodule
`default_nettype wire

// file: verilog/sacc_defs.svh
// Constants of the converter control block: counts, codes and reset values
`ifndef SACC_DEFS_SVH
`define SACC_DEFS_SVH
`define SACC_NUM_CH 8
`define SACC_CH_W 3
`define SACC_RES_W 10
`define SACC_LOW_RES_W 8
`define SACC_CONV_CYCLES 4'hA
`define SACC_DIV_W 6
`define SACC_SH_W 4
`define SACC_STARTUP_W 5
`define SACC_TRIG_TIMER0 3'h0
`define SACC_TRIG_TIMER1 3'h1
`define SACC_TRIG_TIMER2 3'h2
`define SACC_TRIG_EXT 3'h6
`define SACC_SAR_FIRST 10'h200
`define SACC_RST_RESULT 10'h000
`define SACC_RST_CHAN 8'h00
`endif

// file: verilog/sacc_pkg.sv
// Types shared by the converter control block
package sacc_pkg;
   typedef enum logic [2:0] {
      SACC_IDLE = 3'b000,
      SACC_STARTUP = 3'b001,
      SACC_SAMPLE = 3'b010,
      SACC_CONVERT = 3'b011,
      SACC_STORE = 3'b100
   } sacc_state_t;
endpackage

// file: verilog/sacc_clk_div.sv
// Converter clock divider: period is 2*(select+1) system clocks
`timescale 1ns/100ps
`default_nettype none
`include "sacc_defs.svh"
module sacc_clk_div #(
   parameter int DIV_W = `SACC_DIV_W
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_run,
   input wire logic [DIV_W-1:0] i_clock_divider_select,
   output logic o_adc_clk,
   output logic o_tick
);
   logic [DIV_W-1:0] cnt_q;
   logic clk_q;

   initial begin
      if (DIV_W < 1) $error("sacc_clk_div: DIV_W must be at least 1");
   end

   // Half period is select+1 system clocks
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q <= '0;
         clk_q <= 1'b0;
      end else if (!i_run) begin
         cnt_q <= '0;
         clk_q <= 1'b0;
      end else if (cnt_q >= i_clock_divider_select) begin
         cnt_q <= '0;
         clk_q <= ~clk_q;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   assign o_adc_clk = clk_q;
   // One tick per converter clock period, at its rising edge
   assign o_tick = i_run && !clk_q && (cnt_q >= i_clock_divider_select);
endmodule
`default_nettype wire

// file: verilog/sacc_result_mem.sv
// Per-channel result store with registered read data
`timescale 1ns/100ps
`default_nettype none
`include "sacc_defs.svh"
module sacc_result_mem #(
   parameter int DEPTH = `SACC_NUM_CH,
   parameter int AW = `SACC_CH_W,
   parameter int DW = `SACC_RES_W
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_clear,
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [DW-1:0] i_wdata,
   input wire logic i_re,
   input wire logic [AW-1:0] i_raddr,
   output logic [DW-1:0] o_rdata
);
   logic [DW-1:0] mem_q [DEPTH];

   initial begin
      if (DEPTH > (1 << AW)) $error("sacc_result_mem: DEPTH exceeds address range");
   end

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_word
         always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               mem_q[g] <= '0;
            end else if (i_clear) begin
               mem_q[g] <= '0;
            end else if (i_we && (i_waddr == AW'(g))) begin
               mem_q[g] <= i_wdata;
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rdata <= '0;
      end else if (i_re) begin
         o_rdata <= mem_q[i_raddr];
      end
   end
endmodule
`default_nettype wire

// file: sim/sacc_conv_ctrl_asserts.sv
// Port-level assertions for the converter control block
`timescale 1ns/100ps
`default_nettype none
`include "sacc_defs.svh"
module sacc_conv_ctrl_asserts #(
   parameter int NUM_CH = 8,
   parameter int CH_W = 3,
   parameter int RES_W = 10
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_sleep_mode,
   input wire logic i_low_resolution_select,
   input wire logic [`SACC_DIV_W-1:0] i_clock_divider_select,
   input wire logic i_rd_chan_result,
   input wire logic [CH_W-1:0] i_rd_chan_addr,
   input wire logic i_rd_last_result,
   input wire logic i_rd_status,
   input wire logic i_dma_attached,
   input wire logic [NUM_CH-1:0] o_chan_enabled,
   input wire logic [NUM_CH-1:0] o_pin_to_adc,
   input wire logic o_adc_power_on,
   input wire logic o_adc_clk,
   input wire logic o_busy,
   input wire logic [CH_W-1:0] o_last_chan,
   input wire logic [NUM_CH-1:0] o_conv_done_flag,
   input wire logic o_result_ready_flag,
   input wire logic [NUM_CH-1:0] o_channel_overrun_flag,
   input wire logic o_general_overrun_flag,
   input wire logic o_converter_irq,
   input wire logic o_dma_req,
   input wire logic o_dma_size_16
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);
   logic [1:0] idle_q;
   logic [7:0] gap_q;
   logic adc_q;
   logic seen_q;
   logic quiet;
   // Reads judged only well clear of a completion, where a set could win
   assign quiet = !o_busy && (idle_q == 2'h3);
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         idle_q <= 2'h0;
      end else begin
         idle_q <= {idle_q[0], !o_busy};
      end
   end
   // First toggle of a run ends the long low phase held while idle, so only later ones are timed
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         adc_q <= 1'h0;
         gap_q <= 8'h00;
         seen_q <= 1'h0;
      end else begin
         adc_q <= o_adc_clk;
         gap_q <= (o_adc_clk != adc_q) ? 8'h01 : gap_q + 8'h01;
         seen_q <= o_busy && (seen_q || (o_adc_clk != adc_q));
      end
   end
   // ******
   // Checks
   // ******
   dma_width_a: assert property (o_dma_size_16 == !i_low_resolution_select)
      else $error("dma transfer size does not follow resolution");
   irq_sources_a: assert property (
      o_converter_irq == (o_result_ready_flag || (|o_conv_done_flag)))
      else $error("interrupt does not follow the flags");
   pin_connect_a: assert property (o_pin_to_adc == o_chan_enabled)
      else $error("pin connection differs from channel enables");
   dma_on_ready_a: assert property (
      $rose(o_result_ready_flag) && i_dma_attached |=> o_dma_req ##1 !o_dma_req)
      else $error("no single dma request after ready rose");
   chan_read_clr_a: assert property (
      i_rd_chan_result && quiet |=> !o_conv_done_flag[$past(i_rd_chan_addr)])
      else $error("channel read left its done flag set");
   last_read_clr_a: assert property (
      i_rd_last_result && quiet |=>
      !o_result_ready_flag && !o_conv_done_flag[$past(o_last_chan)])
      else $error("last result read left flags set");
   status_clr_a: assert property (
      i_rd_status && quiet |=> !(|o_channel_overrun_flag) && !o_general_overrun_flag)
      else $error("status read left overrun flags set");
   gen_ovr_cause_a: assert property (
      $rose(o_general_overrun_flag) |-> $past(o_result_ready_flag))
      else $error("general overrun without ready set");
   chan_ovr_cause_a: assert property (
      !(|(o_channel_overrun_flag & ~$past(o_channel_overrun_flag) & ~$past(o_conv_done_flag))))
      else $error("channel overrun without unread result");
   sleep_power_a: assert property (o_adc_power_on == (!i_sleep_mode || o_busy))
      else $error("converter power wrong for mode");
   adc_period_a: assert property (
      (o_adc_clk != adc_q) && seen_q && o_busy |->
      gap_q == ({2'h0, i_clock_divider_select} + 8'h01))
      else $error("converter clock half period wrong");
   cover property ($rose(o_dma_req));
   cover property ($rose(o_general_overrun_flag));
   cover property (i_sleep_mode && o_busy);
endmodule
bind sacc_conv_ctrl sacc_conv_ctrl_asserts #(.NUM_CH(NUM_CH), .CH_W(CH_W), .RES_W(RES_W)) u_chk (
   .i_clk, .i_rst_b, .i_sleep_mode, .i_low_resolution_select, .i_clock_divider_select,
   .i_rd_chan_result, .i_rd_chan_addr, .i_rd_last_result, .i_rd_status, .i_dma_attached,
   .o_chan_enabled, .o_pin_to_adc, .o_adc_power_on, .o_adc_clk, .o_busy, .o_last_chan,
   .o_conv_done_flag, .o_result_ready_flag, .o_channel_overrun_flag, .o_general_overrun_flag,
   .o_converter_irq, .o_dma_req, .o_dma_size_16
);
`default_nettype wire

// file: sim/sacc_analog_model.sv
// Analog input lines seen through the comparator
`timescale 1ns/100ps
`default_nettype none
module sacc_analog_model (
   input wire logic [2:0] i_mux_sel,
   input wire logic [9:0] i_trial,
   input wire logic [7:0][9:0] i_levels,
   output logic o_comp
);
   // Ideal comparator, no noise, so the result equals the level exactly
   assign o_comp = (i_levels[i_mux_sel] >= i_trial);
endmodule
`default_nettype wire

// file: sim/sacc_conv_ctrl_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module sacc_conv_ctrl_tb;
   localparam logic [7:0] ENA = 8'h4A;
   localparam logic [2:0] SEL [5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h3};
   localparam logic [3:0] SRC [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hF};
   logic i_clk = 1'h0;
   logic i_rst_b = 1'h0;
   logic i_sw_reset, i_sw_start, i_hw_trigger_enable, i_ext_trigger_pin, i_sleep_mode;
   logic i_low_resolution_select, i_rd_chan_result, i_rd_last_result, i_rd_status;
   logic i_dma_attached, i_adc_comp, o_adc_power_on, o_adc_clk, o_adc_sample, o_busy;
   logic o_result_ready_flag, o_general_overrun_flag, o_converter_irq, o_dma_req, o_dma_size_16;
   logic [2:0] i_hw_trigger_select, i_timer_output_a, i_rd_chan_addr, o_mux_sel, o_last_chan;
   logic [5:0] i_clock_divider_select;
   logic [4:0] i_startup_time;
   logic [3:0] i_sample_hold_time;
   logic [7:0] i_chan_enable_set, i_chan_enable_clear, o_chan_enabled, o_pin_to_adc;
   logic [7:0] o_conv_done_flag, o_channel_overrun_flag;
   logic [9:0] o_sar_trial, o_chan_result, o_last_result_field;
   logic [7:0][9:0] lv;
   logic [11:0] seq = 12'h000;
   logic smp_q = 1'h0;
   int err_count = 0;
   int compares = 0;
   int cyc = 0;
   int dma_n = 0;
   sacc_conv_ctrl uut (
      .i_clk, .i_rst_b, .i_sw_reset, .i_sw_start, .i_hw_trigger_enable, .i_hw_trigger_select,
      .i_timer_output_a, .i_ext_trigger_pin, .i_low_resolution_select, .i_sleep_mode,
      .i_clock_divider_select, .i_startup_time, .i_sample_hold_time, .i_chan_enable_set,
      .i_chan_enable_clear, .i_rd_chan_result, .i_rd_chan_addr, .i_rd_last_result, .i_rd_status,
      .i_dma_attached, .i_adc_comp, .o_chan_enabled, .o_pin_to_adc, .o_mux_sel, .o_adc_power_on,
      .o_adc_clk, .o_adc_sample, .o_sar_trial, .o_busy, .o_chan_result, .o_last_result_field,
      .o_last_chan, .o_conv_done_flag, .o_result_ready_flag, .o_channel_overrun_flag,
      .o_general_overrun_flag, .o_converter_irq, .o_dma_req, .o_dma_size_16
   );
   sacc_analog_model u_ana (.i_mux_sel(o_mux_sel), .i_trial(o_sar_trial), .i_levels(lv),
      .o_comp(i_adc_comp));
   always #20 i_clk = ~i_clk;
   // Channel order taken at end of sampling, when the mux is surely settled
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (o_dma_req === 1'h1) dma_n <= dma_n + 1;
      if (smp_q === 1'h1 && o_adc_sample === 1'h0) seq <= {seq[8:0], o_mux_sel};
      smp_q <= o_adc_sample;
      if (cyc == 30000) begin
         err_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   // Bit 0 start, 1 last read, 2 status read, 3 soft reset
   task automatic strobe(input logic [3:0] m);
      {i_sw_reset, i_rd_status, i_rd_last_result, i_sw_start} = m;
      tick(1);
      {i_sw_reset, i_rd_status, i_rd_last_result, i_sw_start} = 4'h0;
      tick(1);
   endtask
   task automatic run(output logic got);
      int n;
      n = 0;
      while (o_busy !== 1'h1 && n < 8) begin
         tick(1);
         n++;
      end
      got = o_busy;
      n = 0;
      while (o_busy === 1'h1 && n < 9000) begin
         tick(1);
         n++;
      end
      if (n == 9000) err_count++;
      tick(4);
   endtask
   task automatic adc_edge(output int t);
      @(o_adc_clk);
      @(negedge i_clk);
      t = cyc;
   endtask
   function automatic logic [11:0] ex(input logic [2:0] c, input logic lr);
      return lr ? {4'h0, lv[c][9:2]} : {2'h0, lv[c]};
   endfunction
   function automatic logic [11:0] fl();
      return {2'h0, o_result_ready_flag, o_general_overrun_flag, o_conv_done_flag};
   endfunction
   task automatic rd_all(input logic lr);
      for (int c = 0; c < 8; c++) begin
         if (ENA[c]) begin
            i_rd_chan_result = 1'h1;
            i_rd_chan_addr = 3'(c);
            tick(1);
            i_rd_chan_result = 1'h0;
            tick(1);
            chk("chan result", ex(3'(c), lr), 12'(o_chan_result));
         end
      end
   endtask
   initial begin
      logic b;
      int t0;
      int t1;
      {i_sw_reset, i_sw_start, i_hw_trigger_enable, i_ext_trigger_pin} = 4'h0;
      {i_low_resolution_select, i_sleep_mode, i_rd_chan_result, i_rd_last_result} = 4'h0;
      {i_rd_status, i_hw_trigger_select, i_timer_output_a, i_rd_chan_addr} = 10'h000;
      {i_chan_enable_set, i_chan_enable_clear} = 16'h0000;
      i_clock_divider_select = 6'h01;
      i_startup_time = 5'h03;
      i_sample_hold_time = 4'h2;
      i_dma_attached = 1'h1;
      for (int c = 0; c < 8; c++) begin
         lv[c] = 10'h0A5 + 10'(c) * 10'h071;
      end
      tick(16);
      i_rst_b = 1'h1;
      // ******
      // Sequences, flags and reads
      // ******
      i_chan_enable_set = 8'h4B; // Changed only while idle
      i_chan_enable_clear = 8'h01; // Clear beats set on channel 0
      tick(1);
      {i_chan_enable_set, i_chan_enable_clear} = 16'h0000;
      chk("pin to adc", 12'(ENA), 12'(o_pin_to_adc));
      strobe(4'h1);
      run(b);
      chk("order", 12'h05E, seq);
      chk("last chan", 12'h006, 12'(o_last_chan));
      chk("last result", ex(3'h6, 1'h0), 12'(o_last_result_field));
      chk("flags", 12'h34A, fl());
      chk("channel overrun", 12'h000, 12'(o_channel_overrun_flag));
      strobe(4'h2);
      chk("flags", 12'h10A, fl());
      rd_all(1'h0);
      chk("flags", 12'h100, fl());
      strobe(4'h4);
      chk("flags", 12'h000, fl());
      i_low_resolution_select = 1'h1;
      strobe(4'h1);
      run(b);
      chk("low res last", ex(3'h6, 1'h1), 12'(o_last_result_field));
      chk("dma size", 12'h000, 12'(o_dma_size_16));
      strobe(4'h1);
      run(b);
      chk("channel overrun", 12'(ENA), 12'(o_channel_overrun_flag));
      chk("flags", 12'h34A, fl());
      rd_all(1'h1);
      strobe(4'h4);
      chk("channel overrun", 12'h000, 12'(o_channel_overrun_flag));
      chk("dma requests", 12'h002, 12'(dma_n));
      strobe(4'h2);
      i_low_resolution_select = 1'h0;
      i_dma_attached = 1'h0;
      // ******
      // Triggers, sleep, divider, soft reset
      // ******
      i_hw_trigger_enable = 1'h1;
      for (int k = 0; k < 5; k++) begin
         i_hw_trigger_select = SEL[k];
         tick(1);
         {i_ext_trigger_pin, i_timer_output_a} = SRC[k];
         run(b);
         chk("hw start", 12'(k < 4), 12'(b));
         {i_ext_trigger_pin, i_timer_output_a} = 4'h0;
      end
      strobe(4'h1);
      run(b);
      chk("sw start with hw on", 12'h001, 12'(b));
      i_hw_trigger_enable = 1'h0;
      i_sleep_mode = 1'h1;
      tick(1);
      chk("power idle", 12'h000, 12'(o_adc_power_on));
      strobe(4'h1);
      chk("power busy", 12'h001, 12'(o_adc_power_on));
      strobe(4'h1);
      run(b);
      chk("busy after sleep run", 12'h000, 12'(o_busy));
      i_sleep_mode = 1'h0;
      for (int i = 0; i < 2; i++) begin
         i_clock_divider_select = (i == 0) ? 6'h00 : 6'h3F;
         strobe(4'h1);
         @(o_adc_clk);
         adc_edge(t0);
         adc_edge(t1);
         chk("adc half period", (i == 0) ? 12'h001 : 12'h040, 12'(t1 - t0));
         run(b);
      end
      i_clock_divider_select = 6'h01;
      chk("dma while detached", 12'h002, 12'(dma_n));
      strobe(4'h8);
      chk("enabled after soft reset", 12'h000, 12'(o_chan_enabled));
      strobe(4'h1);
      run(b);
      chk("start with none enabled", 12'h000, 12'(b));
      report_and_stop();
   end
endmodule
`default_nettype wire
